// ---- rtl/ofc_regs.vh ----
// Purpose : constants for the per-channel output format configuration registers
// Assumes : 8-bit register port, byte addresses as printed
// Notes   : definitions only
`ifndef OFC_REGS_VH
`define OFC_REGS_VH
`define OFC_ADDR_CH0        8'h42
`define OFC_ADDR_CH1        8'h4a
`define OFC_CFG_RESET       8'h00
`define OFC_BIT_UNSIGNED    7
`define OFC_W0_MSB          6
`define OFC_W0_LSB          5
`define OFC_W1_MSB          4
`define OFC_W1_LSB          2
`define OFC_AVG_MSB         1
`define OFC_AVG_LSB         0
`define OFC_W0_SENSOR       2'h0
`define OFC_W0_RAW          2'h1
`define OFC_SHIFT_QUARTER   2'h0
`define OFC_SHIFT_HALF      2'h1
`define OFC_SHIFT_ONE       2'h2
`define OFC_SHIFT_TWO       2'h3
`endif

// ---- rtl/ofc_top.v ----
// Purpose : per-channel output format configuration registers and word 0 data selection
// Assumes : register accesses arrive already decoded from the serial links on a byte port
// Notes   : sensitivity scaling uses a fixed-point factor with two fraction bits
`timescale 1ns/100ps
`default_nettype none
`include "ofc_regs.vh"

// Overview of operation
// - shift code 0..3 scales by 0.25, 0.5, 1, 2 with user multiplier.
// - channel 0 config at 0x42, channel 1 at 0x4a, 8 bits, reset zero.
// - both registers read/write and covered by register array error check.
// - access allowed in DSI3, SPI, I2C and PSI5 programming modes.
// - bit7 unsigned, bits6:5 word0 source, bits4:2 word1 source, bits1:0 averaging.
// - unsigned bit selects signed or unsigned sensor data output.
// - word0 source selector picks data for sensor word 0 bytes.
// - code 00 gives sensor data with filter-selected offset cancel.
// - code 01 gives sensor data without offset cancellation.
// - codes 10 and 11 give temperature data in word 0.
// - changing averaging selector resets that channel's processing path.
module ofc_top #(
  parameter DW = 16
) (
  // clock and reset
  input  wire          REF_CLK,
  input  wire          SYS_RST,
  // register port from the serial link decoders
  input  wire          REG_WR,
  input  wire          REG_RD,
  input  wire [7:0]    REG_ADDR,
  input  wire [7:0]    REG_WDATA,
  input  wire          LINK_MODE_OK,
  output reg  [7:0]    REG_RDATA,
  output wire          REG_HIT,
  // channel data sources, signed two's complement
  input  wire [DW-1:0] CH0_OC_DATA,
  input  wire [DW-1:0] CH0_RAW_DATA,
  input  wire [DW-1:0] CH1_OC_DATA,
  input  wire [DW-1:0] CH1_RAW_DATA,
  input  wire [DW-1:0] TEMP_DATA,
  // sensitivity scaling
  input  wire [1:0]    CH0_SHIFT,
  input  wire [1:0]    CH1_SHIFT,
  input  wire [7:0]    CH0_MULT,
  input  wire [7:0]    CH1_MULT,
  // outputs
  output reg  [DW-1:0] CH0_WORD0,
  output reg  [DW-1:0] CH1_WORD0,
  output reg  [17:0]   CH0_GAIN,
  output reg  [17:0]   CH1_GAIN,
  output wire [2:0]    CH0_WORD1_SEL,
  output wire [2:0]    CH1_WORD1_SEL,
  output wire [1:0]    CH0_AVG_SEL,
  output wire [1:0]    CH1_AVG_SEL,
  output reg           CH0_PATH_RST,
  output reg           CH1_PATH_RST,
  output wire [15:0]   CFG_IMAGE
);

  // decoded access qualifiers
  wire          wr_ok;
  wire          rd_ok;
  wire          hit0;
  wire          hit1;
  // stored configuration bytes and their next values
  reg  [7:0]    cfg0_r;
  reg  [7:0]    cfg1_r;
  reg  [7:0]    cfg0_nxt;
  reg  [7:0]    cfg1_nxt;
  // restart pulses for the channel signal paths
  reg           path_rst0_nxt;
  reg           path_rst1_nxt;
  // read data and derived output values
  reg  [7:0]    rdata_nxt;
  reg  [DW-1:0] word0_ch0_nxt;
  reg  [DW-1:0] word0_ch1_nxt;
  reg  [17:0]   gain_ch0_nxt;
  reg  [17:0]   gain_ch1_nxt;

  // address compare shared by both channel decoders
  function addr_is;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // a restart is due only when the averaging period really changes,
  // so rewriting the same period keeps the signal path running
  function avg_changed;
    input [7:0] old_cfg;
    input [7:0] new_cfg;
    begin
      avg_changed = old_cfg[`OFC_AVG_MSB:`OFC_AVG_LSB] !=
                    new_cfg[`OFC_AVG_MSB:`OFC_AVG_LSB];
    end
  endfunction

  // word 0 source mux and sign format; temperature keeps its own format
  function [DW-1:0] word0_pick;
    input [7:0]    cfg;
    input [DW-1:0] oc;
    input [DW-1:0] raw;
    input [DW-1:0] tmp;
    reg   [DW-1:0] d;
    begin
      case (cfg[`OFC_W0_MSB:`OFC_W0_LSB])
        `OFC_W0_SENSOR: d = oc;
        `OFC_W0_RAW:    d = raw;
        default:        d = tmp;
      endcase
      // unsigned: flip the sign bit to offset binary, sensor data only
      if (cfg[`OFC_W0_MSB]) begin
        word0_pick = d;
      end else if (cfg[`OFC_BIT_UNSIGNED]) begin
        word0_pick = {~d[DW-1], d[DW-2:0]};
      end else begin
        word0_pick = d;
      end
    end
  endfunction

  // factor in quarters times multiplier: 0.25 -> 1, 2 -> 8
  function [17:0] gain_of;
    input [1:0] sh;
    input [7:0] m;
    begin
      case (sh)
        `OFC_SHIFT_QUARTER: gain_of = {10'h000, m};
        `OFC_SHIFT_HALF:    gain_of = {9'h000, m, 1'b0};
        `OFC_SHIFT_ONE:     gain_of = {8'h00, m, 2'h0};
        `OFC_SHIFT_TWO:     gain_of = {7'h00, m, 3'h0};
        default:            gain_of = 18'h00000;
      endcase
    end
  endfunction

  // access is refused outside the link modes that may reach these registers
  assign wr_ok = REG_WR & LINK_MODE_OK;
  assign rd_ok = REG_RD & LINK_MODE_OK;
  assign hit0  = addr_is(REG_ADDR, `OFC_ADDR_CH0);
  assign hit1  = addr_is(REG_ADDR, `OFC_ADDR_CH1);

  // next configuration bytes; each address reaches one channel only
  always @* begin
    cfg0_nxt      = cfg0_r;
    cfg1_nxt      = cfg1_r;
    path_rst0_nxt = 1'b0;
    path_rst1_nxt = 1'b0;
    if (wr_ok & hit0) begin
      cfg0_nxt      = REG_WDATA;
      path_rst0_nxt = avg_changed(cfg0_r, REG_WDATA);
    end
    if (wr_ok & hit1) begin
      cfg1_nxt      = REG_WDATA;
      path_rst1_nxt = avg_changed(cfg1_r, REG_WDATA);
    end
  end

  // next read data; unmapped reads give zero, refused reads keep the last byte
  always @* begin
    rdata_nxt = REG_RDATA;
    if (rd_ok) begin
      if (hit0) begin
        rdata_nxt = cfg0_r;
      end else if (hit1) begin
        rdata_nxt = cfg1_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  // word 0 and gain follow config and sources one clock late
  always @* begin
    word0_ch0_nxt = word0_pick(cfg0_r, CH0_OC_DATA, CH0_RAW_DATA, TEMP_DATA);
    word0_ch1_nxt = word0_pick(cfg1_r, CH1_OC_DATA, CH1_RAW_DATA, TEMP_DATA);
    gain_ch0_nxt  = gain_of(CH0_SHIFT, CH0_MULT);
    gain_ch1_nxt  = gain_of(CH1_SHIFT, CH1_MULT);
  end

  // configuration storage and one-cycle restart pulses
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg0_r       <= `OFC_CFG_RESET;
      cfg1_r       <= `OFC_CFG_RESET;
      CH0_PATH_RST <= 1'b0;
      CH1_PATH_RST <= 1'b0;
    end else begin
      cfg0_r       <= cfg0_nxt;
      cfg1_r       <= cfg1_nxt;
      CH0_PATH_RST <= path_rst0_nxt;
      CH1_PATH_RST <= path_rst1_nxt;
    end
  end

  // read data registered; it holds until the next allowed read
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rdata_nxt;
    end
  end

  // data words and gains registered so outputs come from flip-flops;
  // the extra clock of latency is the price of glitch-free words
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CH0_WORD0 <= {DW{1'b0}};
      CH1_WORD0 <= {DW{1'b0}};
      CH0_GAIN  <= 18'h00000;
      CH1_GAIN  <= 18'h00000;
    end else begin
      CH0_WORD0 <= word0_ch0_nxt;
      CH1_WORD0 <= word0_ch1_nxt;
      CH0_GAIN  <= gain_ch0_nxt;
      CH1_GAIN  <= gain_ch1_nxt;
    end
  end

  // field fan-out; the image feeds the array error checker
  assign REG_HIT       = hit0 | hit1;
  assign CH0_WORD1_SEL = cfg0_r[`OFC_W1_MSB:`OFC_W1_LSB];
  assign CH1_WORD1_SEL = cfg1_r[`OFC_W1_MSB:`OFC_W1_LSB];
  assign CH0_AVG_SEL   = cfg0_r[`OFC_AVG_MSB:`OFC_AVG_LSB];
  assign CH1_AVG_SEL   = cfg1_r[`OFC_AVG_MSB:`OFC_AVG_LSB];
  assign CFG_IMAGE     = {cfg1_r, cfg0_r};

endmodule
`default_nettype wire

// ---- verif/ofc_top_assertions.sv ----
// Purpose: port checks for ofc_top
// Assumes: one clock, async high reset
// Notes: bound from the bench
`timescale 1ns/100ps
`default_nettype none
module ofc_top_assertions (
  // register port
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        LINK_MODE_OK,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        REG_HIT,
  // channel outputs
  input wire logic [1:0]  CH0_AVG_SEL,
  input wire logic [2:0]  CH0_WORD1_SEL,
  input wire logic        CH0_PATH_RST,
  input wire logic [15:0] CFG_IMAGE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  hit_decode_a: assert property (REG_HIT == (REG_ADDR == 8'h42 || REG_ADDR == 8'h4a))
    else $error("hit");
  ch0_write_a: assert property (REG_WR && LINK_MODE_OK && REG_ADDR == 8'h42 |=>
    CFG_IMAGE[7:0] == $past(REG_WDATA) && $stable(CFG_IMAGE[15:8])) else $error("ch0 wr");
  ch1_write_a: assert property (REG_WR && LINK_MODE_OK && REG_ADDR == 8'h4a |=>
    CFG_IMAGE[15:8] == $past(REG_WDATA) && $stable(CFG_IMAGE[7:0])) else $error("ch1 wr");
  read_data_a: assert property (REG_RD && LINK_MODE_OK && REG_HIT && !REG_WR |=>
    REG_RDATA == ($past(REG_ADDR[3]) ? CFG_IMAGE[15:8] : CFG_IMAGE[7:0])) else $error("rd");
  mode_gate_a: assert property (!LINK_MODE_OK |=> $stable(CFG_IMAGE) && $stable(REG_RDATA))
    else $error("gate");
  avg_field_a: assert property (CH0_AVG_SEL == CFG_IMAGE[1:0]) else $error("avg");
  word1_field_a: assert property (CH0_WORD1_SEL == CFG_IMAGE[4:2]) else $error("w1");
  path_reset_a: assert property (CH0_PATH_RST == (CH0_AVG_SEL != $past(CH0_AVG_SEL)))
    else $error("prst");
endmodule
`default_nettype wire

// ---- verif/ofc_top_bench.sv ----
// Purpose: directed bench for ofc_top
// Assumes: 100 MHz clock, reset held 6 cycles
// Notes: expected words follow the config rules
`timescale 1ns/100ps
`default_nettype none
module ofc_top_bench;
  logic REF_CLK=0, SYS_RST=1, REG_WR=0, REG_RD=0, LINK_MODE_OK=1;
  logic [7:0] REG_ADDR=0, REG_WDATA=0, CH0_MULT=8'hf0, CH1_MULT=8'h76;
  logic [15:0] CH0_OC_DATA=16'h1234, CH0_RAW_DATA=16'h8001, CH1_OC_DATA=16'h0055;
  logic [15:0] CH1_RAW_DATA=16'h0066, TEMP_DATA=16'h0abc;
  logic [1:0] CH0_SHIFT=0, CH1_SHIFT=2;
  wire [7:0] REG_RDATA;
  wire REG_HIT, CH0_PATH_RST, CH1_PATH_RST;
  wire [15:0] CH0_WORD0, CH1_WORD0, CFG_IMAGE;
  wire [17:0] CH0_GAIN, CH1_GAIN;
  wire [2:0] CH0_WORD1_SEL, CH1_WORD1_SEL;
  wire [1:0] CH0_AVG_SEL, CH1_AVG_SEL;
  int error_cnt=0, num_checks=0, cyc=0;
  ofc_top i_ofc_top (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .LINK_MODE_OK(LINK_MODE_OK),
    .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT),
    .CH0_OC_DATA(CH0_OC_DATA), .CH0_RAW_DATA(CH0_RAW_DATA),
    .CH1_OC_DATA(CH1_OC_DATA), .CH1_RAW_DATA(CH1_RAW_DATA), .TEMP_DATA(TEMP_DATA),
    .CH0_SHIFT(CH0_SHIFT), .CH1_SHIFT(CH1_SHIFT), .CH0_MULT(CH0_MULT), .CH1_MULT(CH1_MULT),
    .CH0_WORD0(CH0_WORD0), .CH1_WORD0(CH1_WORD0), .CH0_GAIN(CH0_GAIN), .CH1_GAIN(CH1_GAIN),
    .CH0_WORD1_SEL(CH0_WORD1_SEL), .CH1_WORD1_SEL(CH1_WORD1_SEL),
    .CH0_AVG_SEL(CH0_AVG_SEL), .CH1_AVG_SEL(CH1_AVG_SEL),
    .CH0_PATH_RST(CH0_PATH_RST), .CH1_PATH_RST(CH1_PATH_RST), .CFG_IMAGE(CFG_IMAGE)
  );
  initial forever #5 REF_CLK = ~REF_CLK;
  // hang guard: the sequence needs well under 200 cycles
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc > 2000) begin
      error_cnt++;
      end_sim;
    end
  end
  task chk(input logic [17:0] g, e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge REF_CLK);
    {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
    @(posedge REF_CLK);
    REG_WR <= 0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge REF_CLK);
    {REG_RD, REG_ADDR} <= {1'b1, a};
    @(posedge REF_CLK);
    REG_RD <= 0;
    #1 chk(REG_RDATA, e);
  endtask
  // config lands one edge, the word one edge later
  task settle;
    repeat (2) @(posedge REF_CLK);
    #1;
  endtask
  task end_sim;
    $display("mismatches %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge REF_CLK);
    SYS_RST <= 0;
    rd(8'h42, 8'h00);
    rd(8'h4a, 8'h00);
    wr(8'h42, 8'h81);
    settle;
    chk(CH0_WORD0, 16'h9234);
    chk(CH1_WORD0, 16'h0055);
    wr(8'h42, 8'h20);
    settle;
    chk(CH0_WORD0, 16'h8001);
    wr(8'h42, 8'ha0);
    settle;
    chk(CH0_WORD0, 16'h0001);
    wr(8'h42, 8'hc0);
    settle;
    chk(CH0_WORD0, 16'h0abc);
    rd(8'h42, 8'hc0);
    rd(8'h43, 8'h00);
    wr(8'h42, 8'h60);
    settle;
    chk(CH0_WORD0, 16'h0abc);
    @(posedge REF_CLK) LINK_MODE_OK <= 0;
    wr(8'h4a, 8'hff);
    rd(8'h42, 8'h00);
    @(posedge REF_CLK) LINK_MODE_OK <= 1;
    rd(8'h4a, 8'h00);
    wr(8'h4a, 8'h1e);
    #1 chk(CH1_PATH_RST, 1'b1);
    settle;
    chk(CH1_PATH_RST, 1'b0);
    chk(CH1_AVG_SEL, 2'h2);
    chk(CH1_WORD1_SEL, 3'h7);
    chk(CH1_WORD0, 16'h0055);
    chk(CH1_GAIN, 18'h001d8);
    for (int s = 0; s < 4; s++) begin
      @(posedge REF_CLK) CH0_SHIFT <= 2'(s);
      settle;
      chk(CH0_GAIN, 18'(240 << s));
    end
    end_sim;
  end
endmodule
bind ofc_top ofc_top_assertions i_ofc_top_assertions (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .LINK_MODE_OK(LINK_MODE_OK),
  .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT), .CH0_AVG_SEL(CH0_AVG_SEL),
  .CH0_WORD1_SEL(CH0_WORD1_SEL), .CH0_PATH_RST(CH0_PATH_RST), .CFG_IMAGE(CFG_IMAGE)
);
`default_nettype wire
